/* logic/smtcbm_pkg.sv */
// Package for the simple bus monitor circular buffer manager: constants, types and states
package smtcbm_pkg;

  // Host register map
  localparam logic [15:0] SMTCBM_LIST_BASE_OFFSET = 16'h002F;
  localparam logic [15:0] SMTCBM_LIST_BASE_RESET = 16'h0000;

  // Address list word indices
  localparam logic [2:0] SMTCBM_LW_CMD_START = 3'h0;
  localparam logic [2:0] SMTCBM_LW_CMD_NEXT = 3'h1;
  localparam logic [2:0] SMTCBM_LW_CMD_END = 3'h2;
  localparam logic [2:0] SMTCBM_LW_CMD_IRQ = 3'h3;
  localparam logic [2:0] SMTCBM_LW_DAT_START = 3'h4;
  localparam logic [2:0] SMTCBM_LW_DAT_NEXT = 3'h5;
  localparam logic [2:0] SMTCBM_LW_DAT_END = 3'h6;
  localparam logic [2:0] SMTCBM_LW_DAT_IRQ = 3'h7;
  localparam logic [2:0] SMTCBM_LW_LAST = 3'h7;

  // Monitor configuration time-tag select
  localparam logic [1:0] SMTCBM_TT_SEL_48 = 2'h3;

  // Command entry lengths, minus one
  localparam logic [2:0] SMTCBM_ENTRY_LAST_16 = 3'h3;
  localparam logic [2:0] SMTCBM_ENTRY_LAST_48 = 3'h7;

  // Message status word field positions
  localparam int SMTCBM_SW_END_BIT = 15;
  localparam int SMTCBM_SW_BEGUN_BIT = 14;
  localparam int SMTCBM_SW_BUS_BIT = 13;

  // Start-of-message delay after a valid command word
  localparam int SMTCBM_CLK_PERIOD_NS = 50;
  localparam int SMTCBM_BEGUN_DELAY_NS = 3000;
  localparam logic [7:0] SMTCBM_BEGUN_CYCLES =
    8'((SMTCBM_BEGUN_DELAY_NS + SMTCBM_CLK_PERIOD_NS - 1) / SMTCBM_CLK_PERIOD_NS);

  // Per-message facts supplied by the decoder at message end
  typedef struct packed {
    logic [15:0] cmd_word;
    logic [47:0] time_tag;
    logic [15:0] length_bytes;
    logic [15:0] resp_time;
    logic [12:0] err_bits;
  } smtcbm_msg_t;

  // Sequencer states
  typedef enum logic [2:0] {
    SMTCBM_IDLE = 3'b000,
    SMTCBM_LOAD_REQ = 3'b001,
    SMTCBM_LOAD_WAIT = 3'b010,
    SMTCBM_DATA = 3'b011,
    SMTCBM_CMD_WR = 3'b100,
    SMTCBM_PTR_WR = 3'b101
  } smtcbm_state_t;

endpackage

/* logic/smtcbm_circular_buffer_manager.sv */
// Recording side of the simple bus monitor: circular command and data buffers in RAM
// Contract
// RULE1: command entries stay within list words 0..2
// RULE2: data entries stay within list words 4..6
// RULE3: host loads next-pointer words 1 and 5 first
// RULE4: next-pointer words rewritten after every recorded message
// RULE5: word 2 is command buffer rollover address
// RULE6: word 6 is data buffer rollover address
// RULE7: enabled address match on write raises interrupt
// RULE8: host puts data trigger address in word 7
// RULE9: host puts command trigger address in word 3
// RULE10: list word 0 sits at base register 0x002F
// RULE11: command entry is exactly 4 or 8 words
// RULE12: data entry length follows message, 0..35 words
// RULE13: status word stored per message in command buffer
// RULE14: end sets bit 15, clears bit 14
// RULE15: bit 14 set about 3-4 us after command
// RULE16: begun bit only for messages passing filter
// RULE17: bit 13 is 0 bus A, 1 bus B
// RULE18: time-tag select 11 gives eight-word entries
// RULE19: after rollover address continue at start address
`timescale 1ns/1ps
module smtcbm_circular_buffer_manager
  import smtcbm_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Host register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Monitor configuration and interrupt enables
  input wire logic [1:0] tt_sel,
  input wire logic cmd_irq_en,
  input wire logic data_irq_en,
  // Decoder message events
  input wire logic msg_start,
  input wire logic msg_pass,
  input wire logic msg_bus_b,
  input wire logic msg_done,
  input wire smtcbm_msg_t msg_info,
  // Decoder data word stream
  input wire logic data_valid,
  output logic data_ready,
  input wire logic [DATA_W-1:0] data_word,
  // RAM port
  output logic ram_req,
  output logic ram_we,
  output logic [ADDR_W-1:0] ram_addr,
  output logic [DATA_W-1:0] ram_wdata,
  input wire logic ram_ready,
  input wire logic ram_rvalid,
  input wire logic [DATA_W-1:0] ram_rdata,
  // Status and interrupts
  output logic busy,
  output logic message_begun_flag,
  output logic [15:0] message_status_word,
  output logic cmd_addr_irq,
  output logic data_addr_irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  smtcbm_state_t state_q;
  logic [ADDR_W-1:0] base_q;
  logic [ADDR_W-1:0] list_q [0:7];
  logic [2:0] lidx_q;
  logic [2:0] eidx_q;
  logic pidx_q;
  logic [ADDR_W-1:0] cptr_q;
  logic [ADDR_W-1:0] dptr_q;
  logic [ADDR_W-1:0] dblk_q;
  logic end_pend_q;
  smtcbm_msg_t info_q;
  logic bus_q;
  logic begun_q;
  logic ended_q;
  logic [7:0] begun_cnt_q;
  logic begun_run_q;
  logic tt48_q;
  logic [DATA_W-1:0] fifo_q [0:1];
  logic fifo_wp_q, fifo_rp_q;
  logic [1:0] fifo_cnt_q;
  logic fifo_push, fifo_pop, fifo_valid;
  logic acc;
  logic [2:0] entry_last;
  logic [15:0] done_word;
  logic [ADDR_W-1:0] cptr_nxt, dptr_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Host register: address list base pointer
  // Base pointer write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base_q <= ADDR_W'(SMTCBM_LIST_BASE_RESET);
    end else if (reg_wr_en && reg_addr == SMTCBM_LIST_BASE_OFFSET) begin
      base_q <= ADDR_W'(reg_wdata); // see RULE10
    end
  end

  // Register read, zero for any other address
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd_en) begin
      reg_rdata <= (reg_addr == SMTCBM_LIST_BASE_OFFSET) ? 16'(base_q) : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Two-entry data buffer
  // Handshake terms
  assign data_ready = (fifo_cnt_q != 2'h2);
  assign fifo_valid = (fifo_cnt_q != 2'h0);
  assign fifo_push = data_valid && data_ready;
  assign fifo_pop = (state_q == SMTCBM_DATA) && fifo_valid && ram_ready;

  // Buffer storage and pointers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fifo_q[0] <= '0;
      fifo_q[1] <= '0;
      fifo_wp_q <= 1'b0;
      fifo_rp_q <= 1'b0;
      fifo_cnt_q <= 2'h0;
    end else begin
      if (fifo_push) begin
        fifo_q[fifo_wp_q] <= data_word;
        fifo_wp_q <= ~fifo_wp_q;
      end
      if (fifo_pop) begin
        fifo_rp_q <= ~fifo_rp_q;
      end
      case ({fifo_push, fifo_pop})
        2'b10: fifo_cnt_q <= fifo_cnt_q + 2'h1;
        2'b01: fifo_cnt_q <= fifo_cnt_q - 2'h1;
        default: fifo_cnt_q <= fifo_cnt_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Circular pointer advance
  // Roll over to the start address after the end address
  assign cptr_nxt = (cptr_q == list_q[SMTCBM_LW_CMD_END]) ? list_q[SMTCBM_LW_CMD_START] :
                    cptr_q + ADDR_W'(1); // see RULE1 see RULE5 see RULE19
  assign dptr_nxt = (dptr_q == list_q[SMTCBM_LW_DAT_END]) ? list_q[SMTCBM_LW_DAT_START] :
                    dptr_q + ADDR_W'(1); // see RULE2 see RULE6 see RULE19

  // Entry length and final status word
  assign entry_last = tt48_q ? SMTCBM_ENTRY_LAST_48 : SMTCBM_ENTRY_LAST_16; // see RULE11 see RULE18
  always_comb begin
    done_word = {3'b000, info_q.err_bits};
    done_word[SMTCBM_SW_END_BIT] = 1'b1; // see RULE14
    done_word[SMTCBM_SW_BEGUN_BIT] = 1'b0; // see RULE14
    done_word[SMTCBM_SW_BUS_BIT] = bus_q; // see RULE17
  end

  ////////////////////////////////////////////////////////////////////////////////
  // RAM request generation
  // Drive the RAM port from the current state
  always_comb begin
    ram_req = 1'b0;
    ram_we = 1'b0;
    ram_addr = '0;
    ram_wdata = '0;
    case (state_q)
      SMTCBM_LOAD_REQ: begin
        ram_req = 1'b1;
        ram_addr = base_q + ADDR_W'(lidx_q); // see RULE10
      end
      SMTCBM_DATA: begin
        ram_req = fifo_valid;
        ram_we = fifo_valid;
        ram_addr = dptr_q; // see RULE2
        ram_wdata = fifo_q[fifo_rp_q]; // see RULE12
      end
      SMTCBM_CMD_WR: begin
        ram_req = 1'b1;
        ram_we = 1'b1;
        ram_addr = cptr_q; // see RULE1
        if (tt48_q) begin
          case (eidx_q)
            3'h0: ram_wdata = DATA_W'(info_q.time_tag[15:0]);
            3'h1: ram_wdata = DATA_W'(info_q.time_tag[31:16]);
            3'h2: ram_wdata = DATA_W'(info_q.time_tag[47:32]);
            3'h3: ram_wdata = DATA_W'(done_word); // see RULE13
            3'h4: ram_wdata = DATA_W'(info_q.resp_time);
            3'h5: ram_wdata = DATA_W'(info_q.length_bytes);
            3'h6: ram_wdata = DATA_W'(dblk_q);
            default: ram_wdata = DATA_W'(info_q.cmd_word);
          endcase
        end else begin
          case (eidx_q)
            3'h0: ram_wdata = DATA_W'(info_q.time_tag[15:0]);
            3'h1: ram_wdata = DATA_W'(done_word); // see RULE13
            3'h2: ram_wdata = DATA_W'(dblk_q);
            default: ram_wdata = DATA_W'(info_q.cmd_word);
          endcase
        end
      end
      SMTCBM_PTR_WR: begin
        ram_req = 1'b1;
        ram_we = 1'b1;
        ram_addr = base_q + ADDR_W'(pidx_q ? SMTCBM_LW_DAT_NEXT : SMTCBM_LW_CMD_NEXT); // see RULE4
        ram_wdata = pidx_q ? DATA_W'(dptr_q) : DATA_W'(cptr_q); // see RULE4
      end
      default: ram_req = 1'b0;
    endcase
  end
  // Accepted RAM request
  assign acc = ram_req && ram_ready;

  ////////////////////////////////////////////////////////////////////////////////
  // Message sequencer
  // State, list load, pointers and entry counters
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= SMTCBM_IDLE;
      lidx_q <= 3'h0;
      eidx_q <= 3'h0;
      pidx_q <= 1'b0;
      cptr_q <= '0;
      dptr_q <= '0;
      dblk_q <= '0;
      tt48_q <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        list_q[i] <= '0;
      end
    end else begin
      case (state_q)
        SMTCBM_IDLE: begin
          if (msg_start && msg_pass) begin
            state_q <= SMTCBM_LOAD_REQ;
            lidx_q <= 3'h0;
            tt48_q <= (tt_sel == SMTCBM_TT_SEL_48); // see RULE18
          end
        end
        SMTCBM_LOAD_REQ: begin
          if (acc) begin
            state_q <= SMTCBM_LOAD_WAIT;
          end
        end
        SMTCBM_LOAD_WAIT: begin
          if (ram_rvalid) begin
            list_q[lidx_q] <= ADDR_W'(ram_rdata);
            if (lidx_q == SMTCBM_LW_LAST) begin
              // Next pointers were loaded by the host before recording
              cptr_q <= list_q[SMTCBM_LW_CMD_NEXT]; // see RULE3
              dptr_q <= list_q[SMTCBM_LW_DAT_NEXT]; // see RULE3
              dblk_q <= list_q[SMTCBM_LW_DAT_NEXT];
              state_q <= SMTCBM_DATA;
            end else begin
              lidx_q <= lidx_q + 3'h1;
              state_q <= SMTCBM_LOAD_REQ;
            end
          end
        end
        SMTCBM_DATA: begin
          if (fifo_pop) begin
            dptr_q <= dptr_nxt; // see RULE12
          end else if (!fifo_valid && end_pend_q) begin
            state_q <= SMTCBM_CMD_WR;
            eidx_q <= 3'h0;
          end
        end
        SMTCBM_CMD_WR: begin
          if (acc) begin
            cptr_q <= cptr_nxt;
            if (eidx_q == entry_last) begin
              state_q <= SMTCBM_PTR_WR; // see RULE11
              pidx_q <= 1'b0;
            end else begin
              eidx_q <= eidx_q + 3'h1;
            end
          end
        end
        SMTCBM_PTR_WR: begin
          if (acc) begin
            if (pidx_q) begin
              state_q <= SMTCBM_IDLE;
            end else begin
              pidx_q <= 1'b1;
            end
          end
        end
        default: state_q <= SMTCBM_IDLE;
      endcase
    end
  end

  // Message end capture; info is held until the entry is written
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      end_pend_q <= 1'b0;
      info_q <= '0;
    end else if (state_q != SMTCBM_IDLE && msg_done && !end_pend_q) begin
      end_pend_q <= 1'b1;
      info_q <= msg_info;
    end else if (state_q == SMTCBM_PTR_WR && acc && pidx_q) begin
      end_pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Live message status bits
  // Begun delay counter, end flag and bus identity
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      begun_q <= 1'b0;
      ended_q <= 1'b0;
      begun_run_q <= 1'b0;
      begun_cnt_q <= 8'h00;
      bus_q <= 1'b0;
    end else if (state_q == SMTCBM_IDLE && msg_start && msg_pass) begin
      begun_run_q <= 1'b1; // see RULE16
      begun_cnt_q <= 8'h01;
      begun_q <= 1'b0;
      ended_q <= 1'b0;
      bus_q <= msg_bus_b; // see RULE17
    end else if (state_q != SMTCBM_IDLE && msg_done && !end_pend_q) begin
      begun_q <= 1'b0; // see RULE14
      ended_q <= 1'b1; // see RULE14
      begun_run_q <= 1'b0;
    end else if (begun_run_q) begin
      if (begun_cnt_q == SMTCBM_BEGUN_CYCLES) begin
        begun_q <= 1'b1; // see RULE15
        begun_run_q <= 1'b0;
      end else begin
        begun_cnt_q <= begun_cnt_q + 8'h01;
      end
    end
  end

  assign busy = (state_q != SMTCBM_IDLE);
  assign message_begun_flag = begun_q;

  // Live status word: end, begun and bus bits, errors once known
  always_comb begin
    message_status_word = {3'b000, ended_q ? info_q.err_bits : 13'h0000};
    message_status_word[SMTCBM_SW_END_BIT] = ended_q;
    message_status_word[SMTCBM_SW_BEGUN_BIT] = begun_q;
    message_status_word[SMTCBM_SW_BUS_BIT] = bus_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Buffer address interrupts
  // One-cycle pulse when the matching RAM address is written
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_addr_irq <= 1'b0;
      data_addr_irq <= 1'b0;
    end else begin
      cmd_addr_irq <= cmd_irq_en && acc && state_q == SMTCBM_CMD_WR &&
                      cptr_q == list_q[SMTCBM_LW_CMD_IRQ]; // see RULE7 see RULE9
      data_addr_irq <= data_irq_en && acc && state_q == SMTCBM_DATA &&
                       dptr_q == list_q[SMTCBM_LW_DAT_IRQ]; // see RULE7 see RULE8
    end
  end

endmodule

/* tb/smtcbm_checker.sv */
// Port checker for the circular buffer manager
`timescale 1ns/1ps
module smtcbm_checker
  import smtcbm_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Host register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // Message events and enables
  input wire logic msg_start,
  input wire logic msg_pass,
  input wire logic msg_bus_b,
  input wire logic cmd_irq_en,
  input wire logic data_irq_en,
  // RAM port
  input wire logic ram_req,
  input wire logic ram_we,
  input wire logic [ADDR_W-1:0] ram_addr,
  input wire logic ram_ready,
  // Status and interrupts
  input wire logic busy,
  input wire logic message_begun_flag,
  input wire logic [15:0] message_status_word,
  input wire logic cmd_addr_irq,
  input wire logic data_addr_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [15:0] base_q;
  logic [7:0] age_q;
  logic bus_q;
  logic acc;
  logic wr_ok;
  assign acc = msg_start && msg_pass && !busy;
  assign wr_ok = ram_req && ram_we && ram_ready;
  // Shadow of the list base register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base_q <= 16'h0000;
    end else if (reg_wr_en && reg_addr == SMTCBM_LIST_BASE_OFFSET) begin
      base_q <= reg_wdata;
    end
  end
  // Cycles since the accepted start, and its bus
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      age_q <= 8'h00;
      bus_q <= 1'b0;
    end else if (acc) begin
      age_q <= 8'h00;
      bus_q <= msg_bus_b;
    end else if (age_q != 8'hFF) begin
      age_q <= age_q + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_acc; msg_start && msg_pass && !busy; endsequence
  sequence s_rd_base; busy && ram_req && !ram_we && ram_addr == ADDR_W'(base_q); endsequence
  property p_first_read; s_acc |=> s_rd_base; endproperty
  property p_hold; ram_req && !ram_ready |=> ram_req && $stable(ram_addr) && $stable(ram_we); endproperty
  property p_filter; msg_start && !msg_pass && !busy |=> !busy; endproperty
  property p_begun; $rose(message_begun_flag) |-> age_q >= 8'h39 && age_q <= 8'h3F; endproperty
  property p_end; $rose(message_status_word[15]) |-> !message_status_word[14] && !message_begun_flag; endproperty
  property p_bus; message_status_word[15] |-> message_status_word[13] == bus_q; endproperty
  property p_cirq; cmd_addr_irq |-> $past(wr_ok) && $past(cmd_irq_en); endproperty
  property p_dirq; data_addr_irq |-> $past(wr_ok) && $past(data_irq_en); endproperty
  property p_done; $fell(busy) |-> $past(wr_ok) && $past(ram_addr) == ADDR_W'(base_q + 16'h0005); endproperty
  property p_rd;
    reg_rd_en |=> reg_rdata == ($past(reg_addr) == SMTCBM_LIST_BASE_OFFSET ? base_q : 16'h0000);
  endproperty
  a_first_read: assert property (p_first_read) else $error("list read not at base");
  a_hold: assert property (p_hold) else $error("RAM request changed before ready");
  a_filter: assert property (p_filter) else $error("filtered message started");
  a_begun: assert property (p_begun) else $error("begun flag timing wrong");
  a_end: assert property (p_end) else $error("end did not clear begun");
  a_bus: assert property (p_bus) else $error("bus bit wrong");
  a_cirq: assert property (p_cirq) else $error("command irq without write");
  a_dirq: assert property (p_dirq) else $error("data irq without write");
  a_done: assert property (p_done) else $error("busy fell before pointer write");
  a_rd: assert property (p_rd) else $error("register read value wrong");
endmodule
bind smtcbm_circular_buffer_manager smtcbm_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

/* tb/smtcbm_ram_model.sv */
// Behavioural RAM answering the manager's requests
`timescale 1ns/1ps
module smtcbm_ram_model (
  // Clock, reset and pacing
  input wire logic clk,
  input wire logic reset_n,
  input wire logic slow,
  // Request side
  input wire logic ram_req,
  input wire logic ram_we,
  input wire logic [15:0] ram_addr,
  input wire logic [15:0] ram_wdata,
  // Answer side
  output logic ram_ready,
  output logic ram_rvalid,
  output logic [15:0] ram_rdata
);
  logic [15:0] mem [0:65535];
  logic [1:0] ph_q;
  logic [15:0] rd_q;
  // Slow mode accepts one request in three cycles
  assign ram_ready = ram_req && (!slow || ph_q == 2'h2);
  // Idle data line shows the inverse of the last word
  assign ram_rdata = ram_rvalid ? rd_q : ~rd_q;
  // Store writes, return reads a cycle later
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_q <= 2'h0;
      ram_rvalid <= 1'b0;
    end else begin
      ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
      ram_rvalid <= ram_ready && !ram_we;
      if (ram_ready && !ram_we) rd_q <= mem[ram_addr];
      if (ram_ready && ram_we) mem[ram_addr] <= ram_wdata;
    end
  end
endmodule

/* tb/test_smtcbm_circular_buffer_manager.sv */
// Self-checking bench for the circular buffer manager
`timescale 1ns/1ps
module test_smtcbm_circular_buffer_manager
  import smtcbm_pkg::*;
;
  typedef struct packed {logic [1:0] tt; logic bus; logic [2:0] n; logic slow; logic den; logic [3:0] len;} smtcbm_row_t;
  localparam logic [15:0] BASE = 16'h0100, CS = 16'h0200, CE = 16'h020B, CI = 16'h0204;
  localparam logic [15:0] DS = 16'h0300, DE = 16'h0305, DI = 16'h0302;
  logic clk, reset_n, reg_wr_en, reg_rd_en, cmd_irq_en, data_irq_en, slow;
  logic msg_start, msg_pass, msg_bus_b, msg_done, data_valid, data_ready;
  logic ram_req, ram_we, ram_ready, ram_rvalid, busy, message_begun_flag, cmd_addr_irq, data_addr_irq;
  logic [1:0] tt_sel;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, data_word, ram_addr, ram_wdata, ram_rdata, message_status_word;
  logic [15:0] cp, dptr, cirq, dirq, ncirq, ndirq;
  smtcbm_msg_t msg_info;
  int err_total, checked, cyc;
  smtcbm_row_t rows [4] = '{'{2'h0, 1'b0, 3'h2, 1'b0, 1'b1, 4'h4}, '{2'h3, 1'b1, 3'h3, 1'b1, 1'b0, 4'h8},
    '{2'h1, 1'b0, 3'h0, 1'b0, 1'b1, 4'h4}, '{2'h2, 1'b1, 3'h4, 1'b1, 1'b1, 4'h4}};

  smtcbm_circular_buffer_manager u_dut (.clk(clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tt_sel(tt_sel), .cmd_irq_en(cmd_irq_en), .data_irq_en(data_irq_en), .msg_start(msg_start),
    .msg_pass(msg_pass), .msg_bus_b(msg_bus_b), .msg_done(msg_done), .msg_info(msg_info),
    .data_valid(data_valid), .data_ready(data_ready), .data_word(data_word), .ram_req(ram_req),
    .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_ready(ram_ready),
    .ram_rvalid(ram_rvalid), .ram_rdata(ram_rdata), .busy(busy), .message_begun_flag(message_begun_flag),
    .message_status_word(message_status_word), .cmd_addr_irq(cmd_addr_irq), .data_addr_irq(data_addr_irq));
  smtcbm_ram_model u_ram (.clk(clk), .reset_n(reset_n), .slow(slow), .ram_req(ram_req), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_ready(ram_ready), .ram_rvalid(ram_rvalid),
    .ram_rdata(ram_rdata));

  ////////////////////////////////////////////////////////////////
  // Clock and cycle count
  always #25 clk = ~clk;
  always @(posedge clk) cyc++;
  // Count interrupt pulses
  always @(posedge clk) begin
    if (cmd_addr_irq === 1'b1) ncirq++;
    if (data_addr_irq === 1'b1) ndirq++;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One register access, read data valid on return
  task automatic reg_op(input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_wr_en = wr;
    reg_rd_en = !wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
  endtask

  function automatic logic [15:0] nxt(input logic [15:0] p, input logic [15:0] s, input logic [15:0] e);
    return (p == e) ? s : p + 16'h0001;
  endfunction

  // Record one message and compare the RAM image
  task automatic run_row(input smtcbm_row_t r, input int i);
    logic [15:0] dp, st;
    logic [15:0] w [8];
    int k, c0;
    dp = dptr;
    @(negedge clk);
    tt_sel = r.tt;
    data_irq_en = r.den;
    cmd_irq_en = r.den;
    slow = r.slow;
    msg_start = 1'b1;
    msg_bus_b = r.bus;
    c0 = cyc;
    @(negedge clk);
    msg_start = 1'b0;
    for (k = 0; k < r.n; k++) begin
      data_valid = 1'b1;
      data_word = 16'hA000 + 16'(i * 16 + k);
      for (int t = 0; t < 200 && !data_ready; t++) @(negedge clk);
      @(negedge clk);
    end
    data_valid = 1'b0;
    while (cyc < c0 + 63) @(negedge clk);
    chk(16'(message_begun_flag), 16'h0001);
    msg_info = '{16'h0800 + 16'(i), 48'h0000_1234_5678 + 48'(i), 16'(2 * r.n + 2), 16'h0304, 13'(i)};
    msg_done = 1'b1;
    @(negedge clk);
    msg_done = 1'b0;
    for (k = 0; k < 300 && busy; k++) @(negedge clk);
    chk(16'(busy), 16'h0000);
    st = {1'b1, 1'b0, r.bus, 13'(i)};
    chk(message_status_word, st);
    chk(16'(message_begun_flag), 16'h0000);
    if (r.len == 4'h8) w = '{msg_info.time_tag[15:0], msg_info.time_tag[31:16], msg_info.time_tag[47:32], st,
      16'h0304, 16'(2 * r.n + 2), dp, msg_info.cmd_word};
    else w = '{msg_info.time_tag[15:0], st, dp, msg_info.cmd_word, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    for (k = 0; k < r.len; k++) begin
      chk(u_ram.mem[cp], w[k]);
      if (cp == CI && r.den) cirq++;
      cp = nxt(cp, CS, CE);
    end
    for (k = 0; k < r.n; k++) begin
      chk(u_ram.mem[dptr], 16'hA000 + 16'(i * 16 + k));
      if (dptr == DI && r.den) dirq++;
      dptr = nxt(dptr, DS, DE);
    end
    chk(u_ram.mem[BASE + 16'h0001], cp);
    chk(u_ram.mem[BASE + 16'h0005], dptr);
  endtask

  // Watchdog: the tests need about 400 cycles
  initial begin
    #(20000 * 50);
    err_total++;
    finish_test();
  end

  // Main sequence
  initial begin
    logic [15:0] lw [8];
    {clk, reset_n, reg_wr_en, reg_rd_en, slow, msg_start, msg_bus_b, msg_done, data_valid} = '0;
    {cmd_irq_en, data_irq_en, msg_pass} = 3'h7;
    {tt_sel, reg_addr, reg_wdata, data_word, cyc, err_total, checked} = '0;
    {ncirq, ndirq, cirq, dirq} = '0;
    msg_info = '0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    lw = '{CS, CS, CE, CI, DS, DS, DE, DI};
    for (int k = 0; k < 8; k++) u_ram.mem[BASE + 16'(k)] = lw[k];
    cp = CS;
    dptr = DS;
    reg_op(1'b0, SMTCBM_LIST_BASE_OFFSET, 16'h0000);
    chk(reg_rdata, SMTCBM_LIST_BASE_RESET);
    reg_op(1'b1, SMTCBM_LIST_BASE_OFFSET, BASE);
    reg_op(1'b1, 16'h0030, 16'hFFFF);
    reg_op(1'b0, SMTCBM_LIST_BASE_OFFSET, 16'h0000);
    chk(reg_rdata, BASE);
    reg_op(1'b0, 16'h0030, 16'h0000);
    chk(reg_rdata, 16'h0000);
    for (int i = 0; i < 4; i++) run_row(rows[i], i);
    chk(ncirq, cirq);
    chk(ndirq, dirq);
    // Filtered command must not start a recording
    @(negedge clk);
    msg_start = 1'b1;
    msg_pass = 1'b0;
    @(negedge clk);
    msg_start = 1'b0;
    msg_pass = 1'b1;
    chk(16'(busy), 16'h0000);
    repeat (70) @(negedge clk);
    chk(16'(message_begun_flag), 16'h0000);
    // Reset in mid-message abandons it and clears the base pointer
    @(negedge clk);
    msg_start = 1'b1;
    @(negedge clk);
    msg_start = 1'b0;
    chk(16'(busy), 16'h0001);
    reset_n = 1'b0;
    @(negedge clk);
    chk(16'(busy), 16'h0000);
    chk(message_status_word, 16'h0000);
    reset_n = 1'b1;
    reg_op(1'b0, SMTCBM_LIST_BASE_OFFSET, 16'h0000);
    chk(reg_rdata, SMTCBM_LIST_BASE_RESET);
    finish_test();
  end
endmodule
